// [hdl/reset_and_stop_recovery_ctrl.sv]
`timescale 1ns/100ps
`default_nettype none
// reset and sleep-exit controller with an ahb-lite register port
module reset_and_stop_recovery_ctrl (
    input  wire logic        CLK_SYS,
    input  wire logic        RSTN,
    // analog and pin sources, asynchronous
    input  wire logic        POWER_LOW,
    input  wire logic        BROWNOUT_DETECT,
    input  wire logic        RESET_PIN_N,
    input  wire logic        DEBUG_PIN_N,
    input  wire logic        WDO_CLK,
    input  wire logic [7:0]  GPIO_PIN,
    // same-clock sources
    input  wire logic        WDT_TIMEOUT,
    input  wire logic        STOP_MODE,
    input  wire logic        SM_CFG_IND,
    // ahb-lite slave
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    // reset outputs
    output logic             CPU_RESET_N,
    output logic             PERIPH_RESET_N,
    output logic             RECOVERY_ACTIVE
);
    import rst_ctrl_pkg::*;

    // byte address of a register index
    function automatic logic hit(input logic [31:0] a, input logic [11:0] idx);
        hit = (a == {18'h0, idx, 2'b00});
    endfunction

    // synchronised pin levels and edges
    logic [12:0] pin_lvl;      // synced levels
    logic [12:0] pin_rise;     // rising pulses
    logic [12:0] pin_fall;     // falling pulses
    logic        pwr_low;      // supply under threshold
    logic        bo_det;       // brownout seen
    logic        rpin_n;       // reset pin level
    logic        dpin_fall;    // debug pin driven low
    logic        wdo_rise;     // one oscillator cycle
    logic [7:0]  gpio_edge;    // any gpio transition

    // control and status state
    state_t      state_reg;    // hold sequencer
    state_t      state_next;
    reset_type_t rtype_reg;    // type of current hold
    reset_type_t rtype_next;
    cause_t      cause_reg;    // reset cause flags
    cause_t      cause_next;
    logic [6:0]  wdo_cnt_reg;  // oscillator cycles counted
    logic [4:0]  sys_cnt_reg;  // system clocks counted
    logic [2:0]  pin_cnt_reg;  // pin filter count
    logic [7:0]  sel_reg;      // port sub-register select
    logic [7:0]  smr_en_reg;   // per-pin recovery enables
    logic [7:0]  dbgctl_reg;   // debugger control
    logic [7:0]  opt_reg;      // timeout action option
    ahb_req_t    req_reg;      // pending data phase
    logic [31:0] rdata_next;   // read mux

    // requests
    logic        por_req;      // power or brownout
    logic        pin_req;      // filtered pin assertion
    logic        dbg_req;      // debugger reset bit
    logic        to_rst_req;   // timeout configured as reset
    logic        wake_req;     // any recovery source in stop
    logic        periph_hold;  // system reset in progress
    logic        ap_take;      // address phase accepted
    logic        wr_take;      // data phase write

    // pins and oscillator through two flops each
    // reset pin, debug pin, power and brownout start high, so no false edge
    pin_sync #(
        .WIDTH (13),
        .INIT  (13'h1f00)
    ) u_pin_sync (
        .clk    (CLK_SYS),
        .rstn   (RSTN),
        .pin_in ({RESET_PIN_N, DEBUG_PIN_N, POWER_LOW, BROWNOUT_DETECT,
                  WDO_CLK, GPIO_PIN}),
        .level  (pin_lvl),
        .rise   (pin_rise),
        .fall   (pin_fall)
    );

    // unpack synced vector
    assign rpin_n    = pin_lvl[12];
    assign dpin_fall = pin_fall[11];
    assign pwr_low   = pin_lvl[10];
    assign bo_det    = pin_lvl[9];
    assign wdo_rise  = pin_rise[8];
    assign gpio_edge = pin_rise[7:0] | pin_fall[7:0];

    assign por_req = pwr_low | bo_det;
    assign pin_req = (pin_cnt_reg == PIN_FILT);
    assign dbg_req = dbgctl_reg[DBGCTL_RST_BIT];
    assign to_rst_req = WDT_TIMEOUT & ~STOP_MODE & opt_reg[OPT_TO_RST_BIT];
    assign wake_req = STOP_MODE & (WDT_TIMEOUT | dpin_fall | |(gpio_edge & smr_en_reg));

    assign periph_hold = (state_reg != ST_RUN) && (rtype_reg == RT_SYSTEM);

    // reset pin digital filter
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            pin_cnt_reg <= 3'h0;
        end else if (rpin_n) begin
            // pin released, restart filter
            pin_cnt_reg <= 3'h0;
        end else if (pin_cnt_reg != PIN_FILT) begin
            // low, count towards threshold
            pin_cnt_reg <= pin_cnt_reg + 3'h1;
        end
    end

    // next state, type and cause
    always_comb begin
        state_next = state_reg;
        rtype_next = rtype_reg;
        cause_next = cause_reg;
        cause_next.sm_cfg = SM_CFG_IND;
        cause_next.rsvd   = 3'h0;
        case (state_reg)
            ST_WDO: begin
                if (!por_req && wdo_cnt_reg == WDO_HOLD) begin
                    state_next = ST_SYS;
                end
            end
            ST_SYS: begin
                if (sys_cnt_reg == SYS_HOLD - 5'h01) begin
                    if (!rpin_n) begin
                        state_next = ST_PIN;
                    end else begin
                        state_next = ST_RUN;
                    end
                end
            end
            ST_PIN: begin
                if (rpin_n) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (por_req) begin
                    state_next = ST_WDO;
                end else if (pin_req) begin
                    state_next = ST_WDO;
                    rtype_next = RT_SYSTEM;
                    cause_next.por  = 1'b0;
                    cause_next.stop = 1'b0;
                    cause_next.wdt  = 1'b0;
                    cause_next.pin_reset_flag  = 1'b1;
                end else if (dbg_req) begin
                    state_next = ST_WDO;
                    rtype_next = RT_SYSTEM;
                    cause_next.por  = 1'b1;
                    cause_next.stop = 1'b0;
                    cause_next.wdt  = 1'b0;
                    cause_next.pin_reset_flag  = 1'b0;
                end else if (wake_req) begin
                    state_next = ST_WDO;
                    rtype_next = RT_RECOVERY;
                    cause_next.por  = 1'b0;
                    cause_next.stop = 1'b1;
                    cause_next.wdt  = WDT_TIMEOUT;
                    cause_next.pin_reset_flag  = 1'b0;
                end else if (to_rst_req) begin
                    state_next = ST_WDO;
                    rtype_next = RT_SYSTEM;
                    cause_next.por  = 1'b0;
                    cause_next.stop = 1'b0;
                    cause_next.wdt  = 1'b1;
                    cause_next.pin_reset_flag  = 1'b0;
                end
            end
            default: begin
                state_next = ST_WDO;
            end
        endcase
        if (por_req) begin
            state_next = ST_WDO;
            rtype_next = RT_SYSTEM;
            cause_next.por  = 1'b1;
            cause_next.stop = 1'b0;
            cause_next.wdt  = 1'b0;
            cause_next.pin_reset_flag  = 1'b0;
        end
    end

    // sequencer state and type
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            state_reg <= ST_WDO;
            rtype_reg <= RT_SYSTEM;
        end else begin
            state_reg <= state_next;
            rtype_reg <= rtype_next;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            cause_reg <= CAUSE_RST;
        end else begin
            cause_reg <= cause_next;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            wdo_cnt_reg <= 7'h00;
        end else if (state_reg != ST_WDO || por_req) begin
            // idle or restarted by power
            wdo_cnt_reg <= 7'h00;
        end else if (wdo_rise && wdo_cnt_reg != WDO_HOLD) begin
            wdo_cnt_reg <= wdo_cnt_reg + 7'h01;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            sys_cnt_reg <= 5'h00;
        end else if (state_reg != ST_SYS) begin
            sys_cnt_reg <= 5'h00;
        end else if (sys_cnt_reg != SYS_HOLD) begin
            sys_cnt_reg <= sys_cnt_reg + 5'h01;
        end
    end

    // core reset on both types, peripherals on system only
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            CPU_RESET_N     <= 1'b0;
            PERIPH_RESET_N  <= 1'b0;
            RECOVERY_ACTIVE <= 1'b0;
        end else begin
            CPU_RESET_N     <= (state_next == ST_RUN);
            PERIPH_RESET_N  <= (state_next == ST_RUN) || (rtype_next == RT_RECOVERY);
            RECOVERY_ACTIVE <= (state_next != ST_RUN) && (rtype_next == RT_RECOVERY);
        end
    end

    // bus handshake terms
    assign ap_take = HSEL & HREADY & HTRANS[1];
    assign wr_take = req_reg.valid & req_reg.write;

    // address phase capture
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            req_reg <= '0;
        end else if (HREADY) begin
            req_reg.valid <= ap_take;
            req_reg.write <= HWRITE;
            req_reg.addr  <= HADDR;
        end
    end

    // read data mux
    always_comb begin
        rdata_next = 32'h0;
        if (hit(HADDR, IDX_CAUSE)) begin
            rdata_next = {24'h0, cause_reg};
        end else if (hit(HADDR, IDX_SEL)) begin
            rdata_next = {24'h0, sel_reg};
        end else if (hit(HADDR, IDX_ACC)) begin
            if (sel_reg == SUBREG_SMR_EN) begin
                rdata_next = {24'h0, smr_en_reg};
            end
        end else if (hit(HADDR, IDX_DBGCTL)) begin
            rdata_next = {24'h0, dbgctl_reg};
        end else if (hit(HADDR, IDX_OPT)) begin
            rdata_next = {24'h0, opt_reg};
        end
    end

    // zero wait, always okay; read data loaded at address phase
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            HRDATA    <= 32'h0;
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
            if (ap_take && !HWRITE) begin
                HRDATA <= rdata_next;
            end
        end
    end

    // port select and recovery enables
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            sel_reg    <= SEL_RST;
            smr_en_reg <= SMR_EN_RST;
        end else if (periph_hold) begin
            sel_reg    <= SEL_RST;
            smr_en_reg <= SMR_EN_RST;
        end else if (wr_take) begin
            if (hit(req_reg.addr, IDX_SEL)) begin
                sel_reg <= HWDATA[7:0];
            end else if (hit(req_reg.addr, IDX_ACC) && sel_reg == SUBREG_SMR_EN) begin
                smr_en_reg <= HWDATA[7:0];
            end
        end
    end

    // debugger control, its own reset clears only the request bit
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            dbgctl_reg <= DBGCTL_RST;
        end else if (wr_take && hit(req_reg.addr, IDX_DBGCTL)) begin
            // software write wins over self clear
            dbgctl_reg <= HWDATA[7:0];
        end else if (state_reg != ST_RUN) begin
            dbgctl_reg[DBGCTL_RST_BIT] <= 1'b0;
        end
    end

    // timeout action option
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            opt_reg <= OPT_RST;
        end else if (wr_take && hit(req_reg.addr, IDX_OPT)) begin
            opt_reg <= HWDATA[7:0];
        end
    end

    // hsize unused: only whole words are served
    logic unused_size;
    assign unused_size = ^HSIZE;
endmodule
`default_nettype wire

// [hdl/rst_ctrl_pkg.sv]
`default_nettype none
package rst_ctrl_pkg;
    // register indices, byte address is four times the index
    localparam logic [11:0] IDX_CAUSE  = 12'hff0;
    localparam logic [11:0] IDX_SEL    = 12'hfd0;
    localparam logic [11:0] IDX_ACC    = 12'hfd1;
    localparam logic [11:0] IDX_DBGCTL = 12'hfe0;
    localparam logic [11:0] IDX_OPT    = 12'hfe1;
    // port sub-register code for the recovery enables
    localparam logic [7:0]  SUBREG_SMR_EN = 8'h05;
    // bit positions in the control registers
    localparam int DBGCTL_RST_BIT  = 0;
    localparam int OPT_TO_RST_BIT  = 0;
    // reset values
    localparam logic [7:0]  SEL_RST    = 8'h00;
    localparam logic [7:0]  SMR_EN_RST = 8'h00;
    localparam logic [7:0]  DBGCTL_RST = 8'h00;
    localparam logic [7:0]  OPT_RST    = 8'h01;
    // hold counts
    localparam logic [6:0]  WDO_HOLD   = 7'h42;
    localparam logic [4:0]  SYS_HOLD   = 5'h10;
    localparam logic [2:0]  PIN_FILT   = 3'h4;
    // cause status layout, msb first
    typedef struct packed {
        logic       por;
        logic       stop;
        logic       wdt;
        logic       pin_reset_flag;
        logic [2:0] rsvd;
        logic       sm_cfg;
    } cause_t;
    localparam cause_t CAUSE_RST = '{por: 1'b1, stop: 1'b0, wdt: 1'b0, pin_reset_flag: 1'b0,
                                     rsvd: 3'h0, sm_cfg: 1'b0};
    // captured address phase of a bus transfer
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] addr;
    } ahb_req_t;
    // hold sequencer states
    typedef enum logic [3:0] {
        ST_WDO = 4'h1,
        ST_SYS = 4'h2,
        ST_PIN = 4'h4,
        ST_RUN = 4'h8
    } state_t;
    // kind of reset in progress
    typedef enum logic {
        RT_SYSTEM   = 1'b0,
        RT_RECOVERY = 1'b1
    } reset_type_t;
endpackage
`default_nettype wire

// [hdl/pin_sync.sv]
`timescale 1ns/100ps
`default_nettype none
// two-flop synchroniser with edge pulses from a third stage
module pin_sync #(
    parameter int               WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT  = '0
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);
    logic [WIDTH-1:0] meta_reg;   // first stage, read only by second
    logic [WIDTH-1:0] sync_reg;   // second stage
    logic [WIDTH-1:0] prev_reg;   // delayed copy for edges

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            // per-bit flop chain
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    meta_reg[i] <= INIT[i];
                    sync_reg[i] <= INIT[i];
                    prev_reg[i] <= INIT[i];
                end else begin
                    meta_reg[i] <= pin_in[i];
                    sync_reg[i] <= meta_reg[i];
                    prev_reg[i] <= sync_reg[i];
                end
            end
        end
    endgenerate

    // edges seen only on synced stages, one driver per vector
    assign rise  = sync_reg & ~prev_reg;
    assign fall  = ~sync_reg & prev_reg;
    assign level = sync_reg;
endmodule
`default_nettype wire

// [tb/rst_ctrl_chk.sv]
`timescale 1ns/100ps
`default_nettype none
// port-level checks on the reset controller
module rst_ctrl_chk (
    input  wire logic        CLK_SYS,
    input  wire logic        RSTN,
    input  wire logic        RESET_PIN_N,
    input  wire logic        WDO_CLK,
    input  wire logic        WDT_TIMEOUT,
    input  wire logic        STOP_MODE,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic        HREADY,
    input  wire logic [31:0] HRDATA,
    input  wire logic        HREADYOUT,
    input  wire logic        HRESP,
    input  wire logic        CPU_RESET_N,
    input  wire logic        PERIPH_RESET_N,
    input  wire logic        RECOVERY_ACTIVE
);
    logic       wdo_q;   // last oscillator sample
    logic [7:0] osc_cnt; // oscillator rises seen in a hold
    // counts oscillator rises while the core is held
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            wdo_q   <= 1'b0;
            osc_cnt <= 8'h00;
        end else begin
            wdo_q <= WDO_CLK;
            if (CPU_RESET_N) begin
                osc_cnt <= 8'h00;
            end else if (WDO_CLK && !wdo_q && osc_cnt != 8'hff) begin
                osc_cnt <= osc_cnt + 8'h01;
            end
        end
    end
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);
    // read address phase taken by the slave
    sequence s_rd;
        HSEL && HREADY && HTRANS[1] && !HWRITE;
    endsequence
    // pin low long enough to pass the filter
    sequence s_pin_long;
        !RESET_PIN_N [*8];
    endsequence
    a_periph_needs_cpu: assert property (!PERIPH_RESET_N |-> !CPU_RESET_N)
        else $error("peripherals held while core runs");
    a_recovery_core_only: assert property (RECOVERY_ACTIVE |-> PERIPH_RESET_N && !CPU_RESET_N)
        else $error("sleep-exit hold touched peripherals");
    a_osc_stage_len: assert property ($rose(CPU_RESET_N) |-> osc_cnt >= 8'h44)
        else $error("hold released before oscillator count");
    a_clk_stage_tail: assert property ($rose(CPU_RESET_N) |-> !$past(CPU_RESET_N, 17))
        else $error("clock stage too short");
    a_bus_okay: assert property (HREADYOUT && !HRESP)
        else $error("bus answer not ready okay");
    a_read_upper: assert property (s_rd |=> HRDATA[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_unmapped_zero: assert property (s_rd ##0 HADDR == 32'h100 |=> HRDATA == 32'h0)
        else $error("unmapped read not zero");
    a_status_rsvd: assert property (s_rd ##0 HADDR == 32'h3fc0 |=> HRDATA[3:1] == 3'h0)
        else $error("status reserved bits set");
    a_pin_filter_hit: assert property (s_pin_long |=> !CPU_RESET_N && !PERIPH_RESET_N)
        else $error("long pin low gave no system reset");
    a_pin_keeps_hold: assert property (!RESET_PIN_N [*4] ##1 (!RESET_PIN_N && !CPU_RESET_N)
        |=> !CPU_RESET_N)
        else $error("released while pin low");
    a_wake_recovery: assert property (CPU_RESET_N && STOP_MODE && WDT_TIMEOUT
        |-> ##[1:3] RECOVERY_ACTIVE)
        else $error("timeout in stop gave no recovery");
endmodule
`default_nettype wire

// [tb/core_model.sv]
`timescale 1ns/100ps
`default_nettype none
// core and peripherals held by the controller
module core_model (
    input  wire logic CLK_SYS,
    input  wire logic RSTN,
    input  wire logic CPU_RESET_N,
    input  wire logic PERIPH_RESET_N,
    input  wire logic go_stop,
    output logic      STOP_MODE,
    output int        n_sys,
    output int        n_rec
);
    logic cpu_q; // last core reset level
    // stop on request, left whenever the core is reset
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            cpu_q     <= 1'b0;
            STOP_MODE <= 1'b0;
            n_sys     <= 0;
            n_rec     <= 0;
        end else begin
            cpu_q <= CPU_RESET_N;
            if (!CPU_RESET_N) STOP_MODE <= 1'b0;
            else if (go_stop) STOP_MODE <= 1'b1;
            // count holds by kind at their start
            if (cpu_q && !CPU_RESET_N && !PERIPH_RESET_N) n_sys <= n_sys + 1;
            if (cpu_q && !CPU_RESET_N && PERIPH_RESET_N) n_rec <= n_rec + 1;
        end
    end
endmodule
`default_nettype wire

// [tb/reset_and_stop_recovery_ctrl_test.sv]
`timescale 1ns/100ps
`default_nettype none
// self-checking bench for the reset and sleep-exit controller
module reset_and_stop_recovery_ctrl_test;
    import rst_ctrl_pkg::*;
    logic        CLK_SYS = 1'b0, WDO_CLK = 1'b0, RSTN = 1'b0;
    logic        POWER_LOW = 1'b0, BROWNOUT_DETECT = 1'b0, RESET_PIN_N = 1'b1;
    logic        DEBUG_PIN_N = 1'b1, WDT_TIMEOUT = 1'b0, SM_CFG_IND = 1'b0;
    logic        HSEL = 1'b0, HWRITE = 1'b0, go_stop = 1'b0, STOP_MODE;
    logic [7:0]  GPIO_PIN = 8'h00, en;
    logic [1:0]  HTRANS = 2'h0;
    logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, rd;
    logic        HREADYOUT, HRESP, CPU_RESET_N, PERIPH_RESET_N, RECOVERY_ACTIVE;
    wire         HREADY;
    int          n_errors = 0, checks = 0, cyc = 0, n, i, n_sys, n_rec;
    assign HREADY = HREADYOUT;
    reset_and_stop_recovery_ctrl u_reset_and_stop_recovery_ctrl (
        .CLK_SYS(CLK_SYS), .RSTN(RSTN), .POWER_LOW(POWER_LOW),
        .BROWNOUT_DETECT(BROWNOUT_DETECT), .RESET_PIN_N(RESET_PIN_N),
        .DEBUG_PIN_N(DEBUG_PIN_N), .WDO_CLK(WDO_CLK), .GPIO_PIN(GPIO_PIN),
        .WDT_TIMEOUT(WDT_TIMEOUT), .STOP_MODE(STOP_MODE), .SM_CFG_IND(SM_CFG_IND),
        .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2),
        .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
        .HRESP(HRESP), .CPU_RESET_N(CPU_RESET_N), .PERIPH_RESET_N(PERIPH_RESET_N),
        .RECOVERY_ACTIVE(RECOVERY_ACTIVE));
    core_model u_core_model (
        .CLK_SYS(CLK_SYS), .RSTN(RSTN), .CPU_RESET_N(CPU_RESET_N),
        .PERIPH_RESET_N(PERIPH_RESET_N), .go_stop(go_stop), .STOP_MODE(STOP_MODE),
        .n_sys(n_sys), .n_rec(n_rec));
    // system clock and a free-running oscillator of unrelated phase
    initial begin
        forever #25 CLK_SYS = ~CLK_SYS;
    end
    initial begin
        forever #104 WDO_CLK = ~WDO_CLK;
    end
    // cuts a hung run short
    always @(posedge CLK_SYS) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors = n_errors + 1;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one single transfer, address phase then data phase
    task automatic bus(input logic w, input logic [11:0] idx, input logic [31:0] d);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HWRITE <= w;
        HADDR <= {18'h0, idx, 2'h0};
        do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
        rd = HRDATA;
    endtask
    task automatic rdc(input logic [11:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0);
        chk(rd, exp);
    endtask
    task automatic cpu_is(input logic v);
        chk({31'h0, CPU_RESET_N}, {31'h0, v});
    endtask
    // waits out a hold, n gets its length in clocks
    task automatic hold();
        n = 0;
        do @(posedge CLK_SYS); while (CPU_RESET_N !== 1'b0);
        do begin
            @(posedge CLK_SYS);
            n = n + 1;
        end while (CPU_RESET_N !== 1'b1);
    endtask
    task automatic stop_in();
        go_stop <= 1'b1;
        @(posedge CLK_SYS);
        go_stop <= 1'b0;
    endtask
    // expected status: por, stop, timeout, pin, live config bit
    function automatic logic [31:0] st(input logic p, s, w, e);
        return {24'h0, p, s, w, e, 3'h0, SM_CFG_IND};
    endfunction
    initial begin
        void'($urandom(78));
        repeat (3) @(posedge CLK_SYS);
        RSTN <= 1'b1;
        SM_CFG_IND <= 1'($urandom);
        en = (8'($urandom) & 8'hfc) | 8'h01;
        hold();
        chk({31'h0, n inside {[288:295]}}, 32'h1);
        rdc(IDX_CAUSE, st(1, 0, 0, 0));
        // status ignores writes, unmapped place reads zero
        bus(1'b1, IDX_CAUSE, 32'hff);
        rdc(IDX_CAUSE, st(1, 0, 0, 0));
        rdc(12'h040, 32'h0);
        // recovery enables only behind select code
        bus(1'b1, IDX_SEL, {24'h0, SUBREG_SMR_EN});
        bus(1'b1, IDX_ACC, {24'h0, en});
        rdc(IDX_ACC, {24'h0, en});
        bus(1'b1, IDX_SEL, 32'h04);
        rdc(IDX_ACC, 32'h0);
        // short pin pulses are filtered out
        for (i = 1; i < 4; i++) begin
            RESET_PIN_N <= 1'b0;
            repeat (i) @(posedge CLK_SYS);
            RESET_PIN_N <= 1'b1;
            repeat (12) @(posedge CLK_SYS);
            cpu_is(1'b1);
        end
        // pin held past the hold keeps reset until release
        RESET_PIN_N <= 1'b0;
        repeat (400) @(posedge CLK_SYS);
        cpu_is(1'b0);
        RESET_PIN_N <= 1'b1;
        repeat (8) @(posedge CLK_SYS);
        cpu_is(1'b1);
        rdc(IDX_CAUSE, st(0, 0, 0, 1));
        rdc(IDX_SEL, 32'h0);
        // timeout outside stop resets, unless the option is off
        WDT_TIMEOUT <= 1'b1;
        @(posedge CLK_SYS);
        WDT_TIMEOUT <= 1'b0;
        hold();
        rdc(IDX_CAUSE, st(0, 0, 1, 0));
        bus(1'b1, IDX_OPT, 32'h0);
        WDT_TIMEOUT <= 1'b1;
        @(posedge CLK_SYS);
        WDT_TIMEOUT <= 1'b0;
        repeat (10) @(posedge CLK_SYS);
        cpu_is(1'b1);
        chk(n_sys, 2);
        // each wake source in stop gives a sleep-exit hold
        bus(1'b1, IDX_SEL, {24'h0, SUBREG_SMR_EN});
        bus(1'b1, IDX_ACC, {24'h0, en});
        for (i = 0; i < 3; i++) begin
            stop_in();
            GPIO_PIN <= GPIO_PIN ^ 8'h02;
            repeat (10) @(posedge CLK_SYS);
            cpu_is(1'b1);
            if (i == 0) WDT_TIMEOUT <= 1'b1;
            if (i == 1) DEBUG_PIN_N <= 1'b0;
            if (i == 2) GPIO_PIN <= GPIO_PIN ^ 8'h01;
            @(posedge CLK_SYS);
            WDT_TIMEOUT <= 1'b0;
            DEBUG_PIN_N <= 1'b1;
            hold();
            chk({31'h0, n inside {[288:295]}}, 32'h1);
            rdc(IDX_CAUSE, st(0, 1, i == 0, 0));
            rdc(IDX_ACC, {24'h0, en});
        end
        chk(n_rec, 3);
        // debugger request resets all, its bit clears itself
        bus(1'b1, IDX_DBGCTL, 32'h1);
        hold();
        rdc(IDX_DBGCTL, 32'h0);
        rdc(IDX_CAUSE, st(1, 0, 0, 0));
        // brownout beats a wake source arriving with it
        stop_in();
        BROWNOUT_DETECT <= 1'b1;
        DEBUG_PIN_N <= 1'b0;
        repeat (5) @(posedge CLK_SYS);
        BROWNOUT_DETECT <= 1'b0;
        DEBUG_PIN_N <= 1'b1;
        hold();
        rdc(IDX_CAUSE, st(1, 0, 0, 0));
        chk(n_sys, 4);
        chk(n_rec, 3);
        finish_test();
    end
endmodule
bind reset_and_stop_recovery_ctrl rst_ctrl_chk u_rst_ctrl_chk (
    .CLK_SYS(CLK_SYS), .RSTN(RSTN), .RESET_PIN_N(RESET_PIN_N), .WDO_CLK(WDO_CLK),
    .WDT_TIMEOUT(WDT_TIMEOUT), .STOP_MODE(STOP_MODE), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CPU_RESET_N(CPU_RESET_N),
    .PERIPH_RESET_N(PERIPH_RESET_N), .RECOVERY_ACTIVE(RECOVERY_ACTIVE));
`default_nettype wire
